// File: logic/combo_decode.sv
`timescale 1ns/1ps
`include "netcfg_defines.svh"

// Pure decoder from the latched settings to cycle lengths and allowed modes.
module combo_decode (
   // Settings
   input  wire logic [15:0] cycle_code,
   input  wire logic [15:0] ratio,
   input  wire logic        data32,
   // Results
   output logic      [15:0] comm_period,
   output logic      [16:0] update_period,
   output logic      [3:0]  mode_allowed,
   output logic             combo_bad,
   output logic             pulse_regen_en
);

   wire cyc_83   = (cycle_code == `CYC_CODE_83US);
   wire cyc_166  = (cycle_code == `CYC_CODE_166US);
   wire cyc_500  = (cycle_code == `CYC_CODE_500US);
   wire cyc_1000 = (cycle_code == `CYC_CODE_1000US);
   wire cyc_ok   = cyc_83 | cyc_166 | cyc_500 | cyc_1000;
   wire ratio_1  = (ratio == 16'h0001);
   wire ratio_2  = (ratio == 16'h0002);

   // Cycle decode; reserved codes read as zero period. R1
   assign comm_period = cyc_83  ? `CYC_TENTH_US_83  :
                        cyc_166 ? `CYC_TENTH_US_166 :
                        cyc_500 ? `CYC_TENTH_US_500 :
                        cyc_1000 ? `CYC_TENTH_US_1000 : 16'h0000;

   // Update period is cycle times ratio. R3
   assign update_period = ratio_2 ? {comm_period, 1'b0} : {1'b0, comm_period};

   // Ratio 2 is legal only on the 0.0833 ms and 0.5 ms cycles. R4
   wire ratio_ok = ratio_1 | (ratio_2 & (cyc_83 | cyc_500));

   // The two fast cycles must land on a 0.1666 ms update period. R9
   wire fast_ok  = (cyc_83 & ratio_2) | (cyc_166 & ratio_1);

   // Which modes the table allows for this combination. R9 R10 R11
   wire fast_row = (cyc_83 | cyc_166) & ~data32 & fast_ok;
   wire slow_row = cyc_500 | cyc_1000;
   wire legal    = cyc_ok & ratio_ok & (fast_row | slow_row);
   assign mode_allowed[`MODE_BIT_PROFILE_POS] = legal & slow_row;
   assign mode_allowed[`MODE_BIT_CYCLIC_POS]  = legal;
   assign mode_allowed[`MODE_BIT_CYCLIC_VEL]  = legal;
   assign mode_allowed[`MODE_BIT_CYCLIC_TRQ]  = legal;

   // Anything outside the table is a parameter error. R12
   assign combo_bad = ~legal;

   // Pulse regeneration is off on the fastest cycle. R8
   assign pulse_regen_en = ~cyc_83;

endmodule

// File: logic/netcfg_defines.svh
`ifndef NETCFG_DEFINES_SVH
`define NETCFG_DEFINES_SVH

// Register byte offsets on the Wishbone bus (word aligned).
`define OFS_COMM_CYCLE_SELECT       8'h00
`define OFS_COMMAND_UPDATE_RATIO    8'h04
`define OFS_NETWORK_EXT_FUNCTION    8'h08
`define OFS_STATUS                  8'h0C
`define OFS_MODE_SUPPORT            8'h10
`define OFS_LOAD_CONTROL            8'h14

// Reset values of the writable settings.
`define RST_COMM_CYCLE_SELECT       16'h0003
`define RST_COMMAND_UPDATE_RATIO    16'h0001
`define RST_NETWORK_EXT_FUNCTION    16'h0000

// Communication cycle codes.
`define CYC_CODE_83US               16'h0000
`define CYC_CODE_166US              16'h0001
`define CYC_CODE_500US              16'h0003
`define CYC_CODE_1000US             16'h0006

// Cycle lengths in microseconds times ten (0.0833 ms is 833 tenths).
`define CYC_TENTH_US_83             16'h0341
`define CYC_TENTH_US_166            16'h0682
`define CYC_TENTH_US_500            16'h1388
`define CYC_TENTH_US_1000           16'h2710

// Field positions of the extended network function setting.
`define EXT_BIT_DATA_SIZE           0
`define EXT_BIT_FULL_SYNC           1

// Status register field positions.
`define STAT_BIT_COMBO_ERR          0
`define STAT_BIT_PULSE_REGEN_EN     1
`define STAT_BIT_DATA32             2
`define STAT_BIT_FULL_SYNC          3
`define STAT_BIT_EVALUATED          4

// Mode support field positions.
`define MODE_BIT_PROFILE_POS        0
`define MODE_BIT_CYCLIC_POS         1
`define MODE_BIT_CYCLIC_VEL         2
`define MODE_BIT_CYCLIC_TRQ         3

// Alarm code of the combination error, main 93 sub 5.
`define COMBO_ERR_ALARM_MAIN        8'h5D
`define COMBO_ERR_ALARM_SUB         8'h05
`define COMBO_ERR_PROTECTION_NUM    8'h04

`endif

// File: logic/netcfg_pkg.sv
package netcfg_pkg;

   // Check sequencer states.
   typedef enum logic [1:0] {
      st_wait_load,
      st_evaluate,
      st_hold
   } check_state_type;

   // Control modes selected by the controller's command code.
   typedef enum logic [1:0] {
      mode_profile_position,
      mode_cyclic_position,
      mode_cyclic_velocity,
      mode_cyclic_torque
   } control_mode_type;

endpackage

// File: logic/network_cycle_mode_check.sv
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "netcfg_defines.svh"

// Summary of operation
// R1 - Cycle code 0,1,3,6 selects 0.0833, 0.1666, 0.5, 1.0 ms.
// R2 - Software programs only codes 0, 1, 3 or 6; others are reserved.
// R3 - Update period equals communication period times ratio 1 or 2.
// R4 - Ratio 2 only legal with 0.0833 ms or 0.5 ms cycles.
// R5 - Extended bit 0 selects 16-byte (0) or 32-byte (1) payload.
// R6 - Extended bit 1 selects semi-synchronous (0) or fully synchronous (1).
// R7 - Controller leaves bit 1 clear without the axis timing counter.
// R8 - Encoder pulse regeneration is disabled on the 0.0833 ms cycle.
// R9 - 16-byte fast cycles need 0.1666 ms update; no profile position.
// R10 - 0.5 ms and 1.0 ms cycles support all four modes.
// R11 - 32-byte mode supports no mode on the two fast cycles.
// R12 - Unsupported combination raises the parameter combination error 93.5.
// R13 - Controller uses identical cycle, ratio and extended settings.
// R14 - Controller picks cyclic modes by command code once configured.
// R15 - Cyclic position with longer update uses position change per update.
// R16 - Check is evaluated once at settings load and held until reset; here writing 1 to the load control register also re-runs it.

// ***************************************************************
// Network cycle and control mode configuration checker
// ***************************************************************
module network_cycle_mode_check #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   output logic                   err_o,
   // Network cycle events
   input  wire logic              cycle_tick,
   input  wire logic              mode_req_valid,
   input  wire netcfg_pkg::control_mode_type mode_req,
   // Status outputs
   output logic                   param_combo_error,
   output logic                   pulse_regen_enable,
   output logic                   data_size_32,
   output logic                   full_sync_mode,
   output logic                   update_tick,
   output logic                   mode_accept,
   output logic                   mode_reject,
   output logic      [1:0]        active_mode
);

   // ***************************************************************
   // Elaboration check
   // ***************************************************************
   // The decode slices address bits 7:2, so a narrower bus cannot be served.
   if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("ADDR_W must lie between 8 and 32");
   end

   // ***************************************************************
   // Settings registers
   // ***************************************************************
   logic [15:0] comm_cycle_select_q;
   logic [15:0] command_update_ratio_q;
   logic [15:0] network_extended_function_q;
   // Reset-effective copies, used by the check and the network logic.
   logic [15:0] eff_cycle_q;
   logic [15:0] eff_ratio_q;
   logic [15:0] eff_ext_q;
   netcfg_pkg::check_state_type state_q;
   netcfg_pkg::check_state_type state_d;
   logic        combo_err_q;
   logic        evaluated_q;
   logic [3:0]  mode_allowed_q;
   logic        regen_q;
   logic [31:0] dat_q;
   logic        ack_q;
   logic        err_q;
   logic        accept_q;
   logic        reject_q;
   logic [1:0]  active_mode_q;

   // Bus decode: one cycle answer to a held strobe.
   wire         req       = cyc_i & stb_i & ~ack_q & ~err_q;
   wire [7:0]   ofs       = {adr_i[7:2], 2'b00};
   wire         hit_cyc   = (ofs == `OFS_COMM_CYCLE_SELECT);
   wire         hit_ratio = (ofs == `OFS_COMMAND_UPDATE_RATIO);
   wire         hit_ext   = (ofs == `OFS_NETWORK_EXT_FUNCTION);
   wire         hit_stat  = (ofs == `OFS_STATUS);
   wire         hit_mode  = (ofs == `OFS_MODE_SUPPORT);
   wire         hit_load  = (ofs == `OFS_LOAD_CONTROL);
   wire         upper_ok  = (ADDR_W <= 8) || (adr_i >> 8) == '0;
   wire         mapped    = upper_ok & (hit_cyc | hit_ratio | hit_ext | hit_stat | hit_mode | hit_load);
   wire         wr        = req & we_i & mapped;
   wire         wr_lo     = wr & sel_i[0];
   wire         wr_hi     = wr & sel_i[1];
   // Writing 1 to bit 0 of the load control register re-runs the load.
   wire         load_cmd  = wr_lo & hit_load & dat_i[0];

   // Byte-lane merge of a 16-bit setting.
   function automatic logic [15:0] merge(input logic [15:0] old, input logic lo, input logic hi,
                                         input logic [31:0] d);
      merge = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
   endfunction

   // Software settings take effect only at the next load.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         comm_cycle_select_q         <= `RST_COMM_CYCLE_SELECT;
         command_update_ratio_q      <= `RST_COMMAND_UPDATE_RATIO;
         network_extended_function_q <= `RST_NETWORK_EXT_FUNCTION;
      end else begin
         comm_cycle_select_q         <= merge(comm_cycle_select_q, wr_lo & hit_cyc, wr_hi & hit_cyc, dat_i);
         command_update_ratio_q      <= merge(command_update_ratio_q, wr_lo & hit_ratio, wr_hi & hit_ratio, dat_i);
         network_extended_function_q <= merge(network_extended_function_q, wr_lo & hit_ext, wr_hi & hit_ext, dat_i);
      end
   end

   // ***************************************************************
   // Combination check
   // ***************************************************************
   logic [3:0]  mode_allowed;
   logic        combo_bad;
   logic        regen_en;

   combo_decode u_decode (
      .cycle_code     (eff_cycle_q),
      .ratio          (eff_ratio_q),
      .data32         (eff_ext_q[`EXT_BIT_DATA_SIZE]),
      .comm_period    (),
      .update_period  (),
      .mode_allowed   (mode_allowed),
      .combo_bad      (combo_bad),
      .pulse_regen_en (regen_en)
   );

   // The check runs once after reset, then holds; an explicit load repeats it. R16
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         netcfg_pkg::st_wait_load: state_d = netcfg_pkg::st_evaluate;
         netcfg_pkg::st_evaluate:  state_d = netcfg_pkg::st_hold;
         netcfg_pkg::st_hold:      state_d = load_cmd ? netcfg_pkg::st_wait_load : netcfg_pkg::st_hold;
      endcase
   end

   // Copy settings in the load state so bus writes cannot disturb a held result.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q     <= netcfg_pkg::st_wait_load;
         eff_cycle_q <= `RST_COMM_CYCLE_SELECT;
         eff_ratio_q <= `RST_COMMAND_UPDATE_RATIO;
         eff_ext_q   <= `RST_NETWORK_EXT_FUNCTION;
      end else begin
         state_q <= state_d;
         if (state_q == netcfg_pkg::st_wait_load) begin
            eff_cycle_q <= comm_cycle_select_q;
            eff_ratio_q <= command_update_ratio_q;
            eff_ext_q   <= network_extended_function_q;
         end
      end
   end

   // Results latch at evaluation and stand until the next load. R12 R16
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         combo_err_q    <= 1'b0;
         evaluated_q    <= 1'b0;
         mode_allowed_q <= 4'h0;
         regen_q        <= 1'b0;
      end else if (state_q == netcfg_pkg::st_evaluate) begin
         combo_err_q    <= combo_bad; // R12
         evaluated_q    <= 1'b1;
         mode_allowed_q <= mode_allowed;
         regen_q        <= regen_en; // R8
      end else if (state_q == netcfg_pkg::st_wait_load) begin
         evaluated_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Update period timing and mode selection
   // ***************************************************************
   wire ratio2 = (eff_ratio_q == 16'h0002);

   // Update ticks only run on a good configuration. R15
   update_divider u_div (
      .clk         (clk),
      .rst         (rst),
      .ratio2      (ratio2),
      .cycle_tick  (cycle_tick & evaluated_q & ~combo_err_q),
      .update_tick (update_tick)
   );

   // A requested mode is taken only if the held check allows it. R14
   wire mode_ok = evaluated_q & ~combo_err_q & mode_allowed_q[mode_req];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         accept_q      <= 1'b0;
         reject_q      <= 1'b0;
         active_mode_q <= 2'h0;
      end else begin
         accept_q <= mode_req_valid & mode_ok;
         reject_q <= mode_req_valid & ~mode_ok;
         if (mode_req_valid & mode_ok) begin
            active_mode_q <= mode_req;
         end
      end
   end

   // ***************************************************************
   // Bus read and answer
   // ***************************************************************
   wire [31:0] stat_word = {27'h0,
                            evaluated_q,
                            eff_ext_q[`EXT_BIT_FULL_SYNC],  // R6
                            eff_ext_q[`EXT_BIT_DATA_SIZE],  // R5
                            regen_q,
                            combo_err_q};
   wire [31:0] rd_word = hit_cyc   ? {16'h0, comm_cycle_select_q} :
                         hit_ratio ? {16'h0, command_update_ratio_q} :
                         hit_ext   ? {16'h0, network_extended_function_q} :
                         hit_stat  ? stat_word :
                         hit_mode  ? {28'h0, mode_allowed_q} : 32'h0;

   // Unmapped addresses answer with err instead of ack.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= req & mapped;
         err_q <= req & ~mapped;
         dat_q <= (req & mapped & ~we_i) ? rd_word : 32'h0;
      end
   end

   assign dat_o              = dat_q;
   assign ack_o              = ack_q;
   assign err_o              = err_q;
   assign param_combo_error  = combo_err_q;
   assign pulse_regen_enable = regen_q;
   // Full sync only meaningful when the controller uses the axis timing counter. R7
   assign data_size_32       = eff_ext_q[`EXT_BIT_DATA_SIZE];
   assign full_sync_mode     = eff_ext_q[`EXT_BIT_FULL_SYNC];
   assign mode_accept        = accept_q;
   assign mode_reject        = reject_q;
   assign active_mode        = active_mode_q;

endmodule

// File: logic/update_divider.sv
`timescale 1ns/1ps
`include "netcfg_defines.svh"

// Counts communication cycles and marks update-period boundaries.
module update_divider (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Control
   input  wire logic ratio2,
   input  wire logic cycle_tick,
   // Result
   output logic      update_tick
);

   logic phase_q;
   logic tick_q;

   // With ratio 2 every second cycle carries a fresh position. R15
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= 1'b0;
         tick_q  <= 1'b0;
      end else begin
         phase_q <= cycle_tick ? (ratio2 & ~phase_q) : phase_q;
         tick_q  <= cycle_tick & (~ratio2 | phase_q);
      end
   end

   assign update_tick = tick_q;

endmodule

// File: sim/ctrl_model.sv
`timescale 1ns/1ps
// ********
// Upper-level motion controller model.
// ********
module ctrl_model #(
   parameter int TICK_GAP = 5
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Bench commands
   input  wire logic                    burst_go,
   input  wire logic                    req_go,
   input  wire logic [1:0]              req_code,
   // Network side
   output logic                         cycle_tick,
   output logic                         mode_req_valid,
   output netcfg_pkg::control_mode_type mode_req
);
   int gap_q;
   int left_q;

   // A burst is eight network cycles; this controller is set up exactly like the device.
   // It drives the axis timing counter itself, so full synchronisation may be chosen.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_q <= 0;
         left_q <= 0;
         cycle_tick <= 1'b0;
      end else begin
         cycle_tick <= 1'b0;
         if (burst_go) begin
            left_q <= 8;
         end else if (left_q > 0 && gap_q == 0) begin
            cycle_tick <= 1'b1;
            left_q <= left_q - 1;
            gap_q <= TICK_GAP - 1;
         end else if (gap_q > 0) begin
            gap_q <= gap_q - 1;
         end
      end
   end

   // Command code goes out as a one-cycle pulse; idle code is scrambled so nothing leans on it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_req_valid <= 1'b0;
         mode_req <= netcfg_pkg::mode_profile_position;
      end else begin
         mode_req_valid <= req_go;
         mode_req <= netcfg_pkg::control_mode_type'(req_go ? req_code : ~req_code);
      end
   end
endmodule

// File: sim/netcfg_properties.sv
`timescale 1ns/1ps
// ********
// Port checker for the cycle and mode configuration block.
// ********
module netcfg_checker #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         rst,
   // Register bus
   input wire logic                         cyc_i,
   input wire logic                         stb_i,
   input wire logic                         we_i,
   input wire logic [ADDR_W-1:0]            adr_i,
   input wire logic [31:0]                  dat_o,
   input wire logic                         ack_o,
   input wire logic                         err_o,
   // Network and status
   input wire logic                         cycle_tick,
   input wire logic                         mode_req_valid,
   input wire netcfg_pkg::control_mode_type mode_req,
   input wire logic                         mode_accept,
   input wire logic                         mode_reject,
   input wire logic [1:0]                   active_mode,
   input wire logic                         update_tick,
   input wire logic                         param_combo_error,
   input wire logic                         pulse_regen_enable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [7:0] load_hist_q;

   // Recent load commands; the verdict may only move shortly after one, never on its own.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         load_hist_q <= 8'h00;
      end else begin
         load_hist_q <= {load_hist_q[6:0], cyc_i && stb_i && we_i && adr_i[7:2] == 6'h05};
      end
   end

   // Taking edges of a bus request and of a mode request.
   sequence s_bus_take;
      cyc_i && stb_i && !ack_o && !err_o;
   endsequence
   sequence s_mode_take;
      mode_req_valid;
   endsequence
   sequence s_profile_fast;
      mode_req_valid && !pulse_regen_enable && mode_req == netcfg_pkg::mode_profile_position;
   endsequence

   a_bus_answer: assert property (s_bus_take |=> (ack_o || err_o))
      else $error("Bus request not answered in the next cycle.");
   a_ack_pulse: assert property ((ack_o || err_o) |=> !(ack_o || err_o))
      else $error("Bus answer stood longer than one cycle.");
   a_idle_data: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("Read data not zero outside an acknowledge.");
   a_mode_answer: assert property (s_mode_take |=> mode_accept != mode_reject)
      else $error("Mode request not answered by exactly one pulse.");
   a_error_reject: assert property (s_mode_take and param_combo_error |=> mode_reject)
      else $error("Mode accepted while the combination error is held.");
   a_profile_fast: assert property (s_profile_fast |=> mode_reject)
      else $error("Profile position accepted on the fastest cycle.");
   a_mode_record: assert property (mode_accept |-> active_mode == $past(mode_req))
      else $error("Active mode differs from the accepted request.");
   a_tick_cause: assert property (update_tick |-> $past(cycle_tick) && !param_combo_error)
      else $error("Update tick without a cycle tick or with bad setup.");
   a_error_held: assert property ($changed(param_combo_error) |-> load_hist_q != 8'h00)
      else $error("Combination verdict moved without a load.");
endmodule

bind network_cycle_mode_check netcfg_checker #(.ADDR_W(ADDR_W)) netcfg_checker_i (
   .clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .err_o, .cycle_tick, .mode_req_valid,
   .mode_req, .mode_accept, .mode_reject, .active_mode, .update_tick, .param_combo_error, .pulse_regen_enable
);

// File: sim/network_cycle_mode_check_tb.sv
`timescale 1ns/1ps
// ********
// Self-checking bench for the cycle and mode configuration block.
// ********
module network_cycle_mode_check_tb;
   logic clk = 1'b0;
   logic rst, cyc_i, stb_i, we_i, ack_o, err_o, cycle_tick, mode_req_valid;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, rq;
   logic param_combo_error, pulse_regen_enable, data_size_32, full_sync_mode, update_tick;
   logic mode_accept, mode_reject, re, burst_go, req_go;
   logic [1:0] active_mode, req_code;
   netcfg_pkg::control_mode_type mode_req;
   logic [15:0] lfsr = 16'h002B;
   logic [11:0] tbl [13] = '{12'h020, 12'h010, 12'h110, 12'h120, 12'h311, 12'h322, 12'h613,
                             12'h620, 12'h021, 12'h111, 12'h112, 12'h300, 12'h121};
   int errors = 0;
   int checked = 0;
   int ucnt = 0;
   int c, r, x, mask, eerr, emode, u0;

   network_cycle_mode_check network_cycle_mode_check_i (.clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .err_o, .cycle_tick, .mode_req_valid, .mode_req, .param_combo_error,
      .pulse_regen_enable, .data_size_32, .full_sync_mode, .update_tick, .mode_accept, .mode_reject, .active_mode);
   ctrl_model ctrl_model_i (.clk, .rst, .burst_go, .req_go, .req_code, .cycle_tick, .mode_req_valid, .mode_req);

   // Clock and update tick counting.
   always #12.5 clk = ~clk;
   always @(posedge clk) if (update_tick === 1'b1) ucnt++;

   // Reference of the supported combinations: mode mask, zero when unsupported.
   function automatic int exp_mask(input int c, input int r, input int x);
      if (c == 3 && (r == 1 || r == 2) || c == 6 && r == 1) return 15;
      if (x % 2 == 0 && (c == 0 && r == 2 || c == 1 && r == 1)) return 14;
      return 0;
   endfunction

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One classic bus cycle; request held until the edge that samples the answer.
   task automatic wb(input logic w, input logic [7:0] a, input int d);
      int n;
      @(posedge clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= 32'(d);
      sel_i <= 4'hF;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
      rq = dat_o;
      re = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 20) errors++;
   endtask

   // Mode request through the controller; answer and active mode are sampled together.
   task automatic ask(input int m);
      int n;
      @(posedge clk);
      req_go <= 1'b1;
      req_code <= 2'(m);
      @(posedge clk);
      req_go <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (mode_accept !== 1'b1 && mode_reject !== 1'b1 && n < 8);
      if (n >= 8) errors++;
      chk("mode accept", 32'(mask >> m & 1), {31'h0, mode_accept});
      chk("mode reject", 32'(1 - (mask >> m & 1)), {31'h0, mode_reject});
      if ((mask >> m & 1) == 1) emode = m;
      chk("active mode", 32'(emode), {30'h0, active_mode});
   endtask

   task automatic wrap_up();
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog; a full run needs about 1800 cycles, so this leaves ample margin.
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      wrap_up();
   end

   // Main sequence.
   initial begin
      {rst, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, burst_go, req_go, req_code} = {1'b1, 51'h0};
      sel_i = 4'hF;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      emode = 0;
      eerr = 0;
      wb(1'b0, 8'h00, 0); chk("cycle reset", 32'h3, rq);
      wb(1'b0, 8'h04, 0); chk("ratio reset", 32'h1, rq);
      wb(1'b0, 8'h0C, 0); chk("status reset", 32'h12, rq);
      wb(1'b0, 8'h18, 0); chk("unmapped err", 32'h1, {31'h0, re});
      for (int i = 0; i < 19; i++) begin
         lfsr = lfsr_next(lfsr);
         {c, r, x} = i < 13 ? {32'(tbl[i][11:8]), 32'(tbl[i][7:4]), 32'(tbl[i][3:0])}
                            : {32'(lfsr[1] ? (lfsr[0] ? 6 : 3) : 32'(lfsr[0])), 32'(1 + lfsr[4]),
                               32'(lfsr[6:5])};
         wb(1'b1, 8'h00, c);
         wb(1'b1, 8'h04, r);
         wb(1'b1, 8'h08, x);
         chk("held error", 32'(eerr), {31'h0, param_combo_error});
         wb(1'b1, 8'h14, 1);
         repeat (4) @(posedge clk);
         mask = exp_mask(c, r, x);
         eerr = mask == 0 ? 1 : 0;
         chk("combo error", 32'(eerr), {31'h0, param_combo_error});
         chk("pulse regen", 32'(c != 0), {31'h0, pulse_regen_enable});
         chk("data size", 32'(x & 1), {31'h0, data_size_32});
         chk("full sync", 32'(x >> 1), {31'h0, full_sync_mode});
         wb(1'b0, 8'h00, 0); chk("cycle code", 32'(c), rq);
         wb(1'b0, 8'h0C, 0); chk("status", 32'(16 + 4 * x + 2 * (c != 0) + eerr), rq);
         wb(1'b0, 8'h10, 0); chk("mode support", 32'(mask), rq);
         for (int m = 0; m < 4; m++) ask(m);
         u0 = ucnt;
         @(posedge clk);
         burst_go <= 1'b1;
         @(posedge clk);
         burst_go <= 1'b0;
         repeat (50) @(posedge clk);
         chk("update ticks", 32'(eerr ? 0 : 8 / r), 32'(ucnt - u0));
      end
      // Bad setup, then a reset in mid-run must restore the legal defaults.
      wb(1'b1, 8'h00, 6);
      wb(1'b1, 8'h04, 2);
      wb(1'b1, 8'h14, 1);
      repeat (4) @(posedge clk);
      chk("error before reset", 32'h1, {31'h0, param_combo_error});
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("error after reset", 32'h0, {31'h0, param_combo_error});
      wb(1'b0, 8'h00, 0); chk("cycle after reset", 32'h3, rq);
      wrap_up();
   end
endmodule
